// *** rtl/awf_pkg.sv ***
// Purpose: Shared constants for the add-accumulator-to-file execute block.
// Assumes: AXI4-Lite register access with 32-bit data and byte addresses.
// Notes: Status bit positions match the layout software sees in the status register.
package awf_pkg;

  // Opcode layout.
  localparam logic [5:0] OPC_ADD_ACC_TO_FILE = 6'h09;
  localparam int OPC_TOP_MSB = 15;
  localparam int OPC_TOP_LSB = 10;
  localparam int OPC_DEST_BIT = 9;
  localparam int OPC_ACCESS_BIT = 8;

  // Addressing.
  localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_BANK = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_INDEX = 8'h10;
  localparam logic [7:0] OFS_INFO = 8'h14;

  // Reset values.
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [11:0] INDEX_RESET = 12'h000;

  // Status field positions.
  localparam int ST_CARRY = 0;
  localparam int ST_NIBBLE = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_OVF = 3;
  localparam int ST_NEG = 4;

  // Info register field positions.
  localparam int INFO_BUSY = 16;
  localparam int INFO_SKIP = 17;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Execute phases, Gray coded along the fixed path.
  typedef enum logic [1:0] {
    PH_DECODE = 2'h0,
    PH_READ = 2'h1,
    PH_PROCESS = 2'h3,
    PH_WRITE = 2'h2
  } awf_phase_t;

endpackage

// *** rtl/awf_adder.sv ***
// Purpose: Eight-bit adder with the arithmetic status flags.
// Assumes: Purely combinational; the caller registers the results.
// Notes: Overflow is the signed overflow of two's-complement addition.
`timescale 1ns/1ps
module awf_adder (
  // Operands
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_b,
  // Result and flags
  output logic [7:0] o_sum,
  output logic o_carry,
  output logic o_nibble,
  output logic o_zero,
  output logic o_neg,
  output logic o_ovf
);

  wire [8:0] full_sum = {1'b0, i_a} + {1'b0, i_b};
  wire [4:0] low_sum = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};

  assign o_sum = full_sum[7:0];
  assign o_carry = full_sum[8];
  assign o_nibble = low_sum[4];
  assign o_zero = (full_sum[7:0] == 8'h00);
  assign o_neg = full_sum[7];
  // Same-sign operands giving a result of the other sign.
  assign o_ovf = (i_a[7] == i_b[7]) && (full_sum[7] != i_a[7]);

endmodule

// *** rtl/awf_execute.sv ***
// Purpose: Decode and four-phase execution of the add-accumulator-to-file opcode.
// Assumes: Data memory answers a read strobe with data on the following cycle.
// Notes: Registers are reached over AXI4-Lite; other opcodes are taken and skipped.
`timescale 1ns/1ps

module awf_execute (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Instruction stream
  input wire logic [15:0] i_instr,
  input wire logic i_instr_valid,
  output logic o_instr_ready,
  output logic o_done,
  // Data memory
  output logic [11:0] o_mem_addr,
  output logic o_mem_rd,
  input wire logic [7:0] i_mem_rdata,
  output logic o_mem_we,
  output logic [7:0] o_mem_wdata,
  // AXI4-Lite write address and data
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready
);

  awf_pkg::awf_phase_t phase_reg, phase_next;
  logic [15:0] instr_reg;
  logic [7:0] operand_reg;
  logic [11:0] addr_reg;
  logic [7:0] acc_reg;
  logic [3:0] bank_reg;
  logic [7:0] status_reg;
  logic [11:0] index_reg;
  logic ext_en_reg;
  logic skip_reg;
  logic done_reg;
  logic mem_we_reg;
  logic [7:0] mem_wdata_reg;

  // Bus holding state.
  logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg, rdata_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] bresp_reg, rresp_reg;

  wire instr_take = (phase_reg == awf_pkg::PH_DECODE) && i_instr_valid;
  wire opcode_hit = (i_instr[awf_pkg::OPC_TOP_MSB:awf_pkg::OPC_TOP_LSB] == awf_pkg::OPC_ADD_ACC_TO_FILE);
  wire dest_file = instr_reg[awf_pkg::OPC_DEST_BIT];
  wire [7:0] file_addr = instr_reg[7:0];
  wire in_access = instr_reg[awf_pkg::OPC_ACCESS_BIT];

  wire [3:0] access_bank = (file_addr > awf_pkg::INDEXED_LIMIT) ? awf_pkg::ACCESS_HIGH_BANK
                                                                 : awf_pkg::ACCESS_LOW_BANK;
  wire use_indexed = ext_en_reg && !in_access && (file_addr <= awf_pkg::INDEXED_LIMIT);
  wire [11:0] indexed_addr = index_reg + {4'h0, file_addr};
  wire [11:0] banked_addr = {bank_reg, file_addr};
  wire [11:0] access_addr = {access_bank, file_addr};
  wire [11:0] eff_addr = use_indexed ? indexed_addr : (in_access ? banked_addr : access_addr);

  logic [7:0] sum;
  logic flag_c, flag_nib, flag_z, flag_n, flag_ovf;
  awf_adder u_adder (
    .i_a(acc_reg),
    .i_b(operand_reg),
    .o_sum(sum),
    .o_carry(flag_c),
    .o_nibble(flag_nib),
    .o_zero(flag_z),
    .o_neg(flag_n),
    .o_ovf(flag_ovf)
  );

  wire in_write = (phase_reg == awf_pkg::PH_WRITE);

  wire [7:0] status_exec = {status_reg[7:5], flag_n, flag_ovf, flag_z, flag_nib, flag_c};

  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      awf_pkg::PH_DECODE: begin
        if (instr_take && opcode_hit) begin
          phase_next = awf_pkg::PH_READ;
        end
      end
      awf_pkg::PH_READ: phase_next = awf_pkg::PH_PROCESS;
      awf_pkg::PH_PROCESS: phase_next = awf_pkg::PH_WRITE;
      awf_pkg::PH_WRITE: phase_next = awf_pkg::PH_DECODE;
      default: phase_next = awf_pkg::PH_DECODE;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_reg <= awf_pkg::PH_DECODE;
      instr_reg <= 16'h0000;
      skip_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      if (instr_take) begin
        instr_reg <= i_instr;
        skip_reg <= !opcode_hit;
      end
    end
  end

  // The address is frozen in the read phase so a bank or index write later in the
  // instruction cannot move the write-back away from the location that was read.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      addr_reg <= 12'h000;
      operand_reg <= 8'h00;
    end else begin
      if (phase_reg == awf_pkg::PH_READ) begin
        addr_reg <= eff_addr;
      end
      if (phase_reg == awf_pkg::PH_PROCESS) begin
        operand_reg <= i_mem_rdata;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      mem_we_reg <= 1'b0;
      mem_wdata_reg <= 8'h00;
      done_reg <= 1'b0;
    end else begin
      mem_we_reg <= in_write && dest_file;
      done_reg <= in_write;
      if (in_write && dest_file) begin
        mem_wdata_reg <= sum;
      end
    end
  end

  // Software registers; an execution write wins over a bus write in the same cycle.
  wire bus_write = aw_full_reg && w_full_reg && !bvalid_reg;
  wire [7:0] wr_ofs = aw_addr_reg;
  wire wr_lane0 = bus_write && w_strb_reg[0];
  wire wr_lane1 = bus_write && w_strb_reg[1];
  wire wr_ctrl = wr_lane0 && (wr_ofs == awf_pkg::OFS_CTRL);
  wire wr_acc = wr_lane0 && (wr_ofs == awf_pkg::OFS_ACC);
  wire wr_bank = wr_lane0 && (wr_ofs == awf_pkg::OFS_BANK);
  wire wr_status = wr_lane0 && (wr_ofs == awf_pkg::OFS_STATUS);
  wire wr_index_lo = wr_lane0 && (wr_ofs == awf_pkg::OFS_INDEX);
  wire wr_index_hi = wr_lane1 && (wr_ofs == awf_pkg::OFS_INDEX);
  wire wr_mapped = (wr_ofs == awf_pkg::OFS_CTRL) || (wr_ofs == awf_pkg::OFS_ACC) ||
                   (wr_ofs == awf_pkg::OFS_BANK) || (wr_ofs == awf_pkg::OFS_STATUS) ||
                   (wr_ofs == awf_pkg::OFS_INDEX) || (wr_ofs == awf_pkg::OFS_INFO);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      acc_reg <= awf_pkg::ACC_RESET;
      status_reg <= awf_pkg::STATUS_RESET;
    end else begin
      if (in_write && !dest_file) begin
        acc_reg <= sum;
      end else if (wr_acc) begin
        acc_reg <= w_data_reg[7:0];
      end
      if (in_write) begin
        status_reg <= status_exec;
      end else if (wr_status) begin
        status_reg <= w_data_reg[7:0];
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ext_en_reg <= awf_pkg::CTRL_RESET;
      bank_reg <= awf_pkg::BANK_RESET;
      index_reg <= awf_pkg::INDEX_RESET;
    end else begin
      if (wr_ctrl) begin
        ext_en_reg <= w_data_reg[0];
      end
      if (wr_bank) begin
        bank_reg <= w_data_reg[3:0];
      end
      if (wr_index_lo) begin
        index_reg[7:0] <= w_data_reg[7:0];
      end
      if (wr_index_hi) begin
        index_reg[11:8] <= w_data_reg[11:8];
      end
    end
  end

  // Write channel: address and data are held separately so either may come first.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= awf_pkg::RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= {i_s_axi_awaddr[7:2], 2'h0};
      end
      if (i_s_axi_wvalid && !w_full_reg) begin
        w_full_reg <= 1'b1;
        w_data_reg <= i_s_axi_wdata;
        w_strb_reg <= i_s_axi_wstrb;
      end
      if (bus_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? awf_pkg::RESP_OKAY : awf_pkg::RESP_SLVERR;
      end else if (bvalid_reg && i_s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read channel.
  wire [7:0] rd_ofs = {i_s_axi_araddr[7:2], 2'h0};
  wire rd_take = i_s_axi_arvalid && !rvalid_reg;
  logic [31:0] info_word;
  always_comb begin
    info_word = 32'h0000_0000;
    info_word[11:0] = addr_reg;
    info_word[awf_pkg::INFO_BUSY] = (phase_reg != awf_pkg::PH_DECODE);
    info_word[awf_pkg::INFO_SKIP] = skip_reg;
  end

  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (rd_ofs)
      awf_pkg::OFS_CTRL: rd_mux = {31'h0000_0000, ext_en_reg};
      awf_pkg::OFS_ACC: rd_mux = {24'h00_0000, acc_reg};
      awf_pkg::OFS_BANK: rd_mux = {28'h000_0000, bank_reg};
      awf_pkg::OFS_STATUS: rd_mux = {24'h00_0000, status_reg};
      awf_pkg::OFS_INDEX: rd_mux = {20'h0_0000, index_reg};
      awf_pkg::OFS_INFO: rd_mux = info_word;
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= awf_pkg::RESP_OKAY;
    end else begin
      if (rd_take) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= rd_hit ? awf_pkg::RESP_OKAY : awf_pkg::RESP_SLVERR;
      end else if (rvalid_reg && i_s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  assign o_mem_addr = (phase_reg == awf_pkg::PH_READ) ? eff_addr : addr_reg;
  assign o_mem_rd = (phase_reg == awf_pkg::PH_READ);
  assign o_mem_we = mem_we_reg;
  assign o_mem_wdata = mem_wdata_reg;
  assign o_instr_ready = (phase_reg == awf_pkg::PH_DECODE);
  assign o_done = done_reg;

  assign o_s_axi_awready = !aw_full_reg;
  assign o_s_axi_wready = !w_full_reg;
  assign o_s_axi_bvalid = bvalid_reg;
  assign o_s_axi_bresp = bresp_reg;
  assign o_s_axi_arready = !rvalid_reg;
  assign o_s_axi_rvalid = rvalid_reg;
  assign o_s_axi_rdata = rdata_reg;
  assign o_s_axi_rresp = rresp_reg;

endmodule

// *** verif/awf_sva.sv ***
// Purpose: Timing checks on the execute block ports.
// Assumes: Bound to awf_execute.
// Notes: A skipped opcode must leave the core idle.
`timescale 1ns/1ps
module awf_sva (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Watched ports
  input wire logic [15:0] i_instr,
  input wire logic i_instr_valid,
  input wire logic o_instr_ready,
  input wire logic o_done,
  input wire logic [11:0] o_mem_addr,
  input wire logic o_mem_rd,
  input wire logic o_mem_we
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire tk = i_instr_valid && o_instr_ready;
  wire hit = tk && i_instr[15:10] == awf_pkg::OPC_ADD_ACC_TO_FILE;
  property p_lat; hit |-> ##4 o_done; endproperty
  a_lat: assert property (p_lat) else $error("done late");
  property p_busy; hit |=> !o_instr_ready [*3] ##1 o_instr_ready; endproperty
  a_busy: assert property (p_busy) else $error("ready wrong");
  property p_skip; tk && !hit |=> o_instr_ready ##3 !o_done; endproperty
  a_skip: assert property (p_skip) else $error("skip wrong");
  property p_rd; hit |=> o_mem_rd ##1 !o_mem_rd; endproperty
  a_rd: assert property (p_rd) else $error("read wrong");
  property p_we1; hit && i_instr[9] |-> ##4 o_mem_we; endproperty
  a_we1: assert property (p_we1) else $error("no write");
  property p_we0; hit && !i_instr[9] |-> ##4 !o_mem_we; endproperty
  a_we0: assert property (p_we0) else $error("bad write");
  property p_hi; hit && !i_instr[8] && i_instr[7:0] > 8'h5F |=> o_mem_addr == {4'hF, $past(i_instr[7:0])}; endproperty
  a_hi: assert property (p_hi) else $error("access bank addr");
  property p_same; o_mem_rd |=> o_mem_addr == $past(o_mem_addr) ##2 o_mem_addr == $past(o_mem_addr, 3); endproperty
  a_same: assert property (p_same) else $error("addr moved");
  c_d1: cover property (hit && i_instr[9]);
  c_d0: cover property (hit && !i_instr[9]);
  c_skip: cover property (tk && !hit);
endmodule

// *** verif/awf_mem_model.sv ***
// Purpose: Data register file facing the execute block.
// Assumes: One-cycle read latency.
// Notes: Outside a read the data toggles, so stale data never looks right.
`timescale 1ns/1ps
module awf_mem_model (
  // Clock
  input wire logic i_core_clk,
  // Access
  input wire logic [11:0] i_addr,
  input wire logic i_rd,
  input wire logic i_we,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [4096];
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'(i * 37 + (i >> 8));
    o_rdata = 8'h00;
  end
  always @(posedge i_core_clk) begin
    o_rdata <= i_rd ? mem[i_addr] : ~o_rdata;
    if (i_we) mem[i_addr] <= i_wdata;
  end
endmodule

// *** verif/tb.sv ***
// Purpose: Random and corner test of the execute block.
// Assumes: CTRL 0x00, ACC 0x04, BANK 0x08, STATUS 0x0C, INDEX 0x10.
// Notes: bready, rready and wstrb are held high.
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst = 1'b1, iv = 1'b0, aw_v = 1'b0, w_v = 1'b0, ar_v = 1'b0, ext;
  logic [15:0] instr = 16'h0000;
  logic [7:0] aw_a = 8'h00, ar_a = 8'h00, acc, st, mr, mw;
  logic [31:0] w_d = 32'h00000000;
  logic [3:0] bank;
  logic [11:0] idx, ma;
  logic irdy, done, mrd, mwe, awr, wr, bv, arr, rv;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int num_errors = 0;
  int cmp_count = 0;
  awf_execute DUT (.i_core_clk(clk), .i_rst(rst), .i_instr(instr), .i_instr_valid(iv), .o_instr_ready(irdy),
    .o_done(done), .o_mem_addr(ma), .o_mem_rd(mrd), .i_mem_rdata(mr), .o_mem_we(mwe), .o_mem_wdata(mw),
    .i_s_axi_awaddr(aw_a), .i_s_axi_awvalid(aw_v), .o_s_axi_awready(awr), .i_s_axi_wdata(w_d),
    .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(w_v), .o_s_axi_wready(wr), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bv), .i_s_axi_bready(1'b1), .i_s_axi_araddr(ar_a), .i_s_axi_arvalid(ar_v),
    .o_s_axi_arready(arr), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rv), .i_s_axi_rready(1'b1));
  awf_mem_model u_mem (.i_core_clk(clk), .i_addr(ma), .i_rd(mrd), .i_we(mwe), .i_wdata(mw), .o_rdata(mr));
  initial forever #4 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic hang(input int n);
    if (n >= 40) begin
      num_errors++;
      stop_test();
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh, bh;
    int n;
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      ah = aw_v & awr;
      wh = w_v & wr;
      bh = bv;
      r = bresp;
      @(posedge clk);
      if (ah) aw_v <= 1'b0;
      if (wh) w_v <= 1'b0;
      if (bh) break;
    end
    hang(n);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    int n;
    ar_a <= a;
    ar_v <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      ah = ar_v & arr;
      rh = rv;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ah) ar_v <= 1'b0;
      if (rh) break;
    end
    hang(n);
  endtask
  task automatic exec(input logic [15:0] ins, input logic hit, input logic [11:0] ea, input logic [7:0] sum);
    logic tk;
    int n;
    instr <= ins;
    iv <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      tk = irdy;
      @(posedge clk);
      if (tk) break;
    end
    hang(n);
    iv <= 1'b0;
    for (n = 1; n <= 5; n++) begin
      @(negedge clk);
      if (hit && n == 1) chk("mem_addr", ma, ea);
      if (hit && n == 4) chk("mem_we", mwe, ins[9]);
      if (hit && n == 4 && ins[9]) chk("mem_wdata", mw, sum);
      chk("done", done, hit && n == 4);
      @(posedge clk);
    end
  endtask
  function automatic logic [11:0] eaddr(input logic a, input logic [7:0] f);
    if (a) return {bank, f};
    if (ext && f <= 8'h5F) return idx + 12'(f);
    return (f <= 8'h5F) ? {4'h0, f} : {4'hF, f};
  endfunction
  function automatic logic [7:0] flags(input logic [7:0] a, input logic [7:0] b, input logic [7:0] old);
    logic [8:0] s;
    s = 9'(a) + 9'(b);
    return {old[7:5], s[7], a[7] == b[7] && s[7] != a[7], s[7:0] == 8'h00, 5'(a[3:0]) + 5'(b[3:0]) > 5'h0F, s[8]};
  endfunction
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] ins;
    logic [11:0] ea, last_ea;
    logic [7:0] m, s;
    logic hit;
    void'($urandom(32'h6243787D));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axr(8'h04, d, r);
    chk("acc_reset", d, 32'h00000000);
    axr(8'h20, d, r);
    chk("unmapped", r, awf_pkg::RESP_SLVERR);
    axw(8'h20, 32'h0000_00FF, r);
    chk("unmapped_wr", r, awf_pkg::RESP_SLVERR);
    last_ea = 12'h000;
    for (int i = 0; i < 60; i++) begin
      {acc, st, bank, idx} = 32'($urandom);
      ext = (i < 4) ? 1'b1 : 1'($urandom);
      ins = {6'h09, 10'($urandom)};
      if (i < 4) ins[9:0] = {i[1:0], 8'h5F + 8'(i[0])};
      if (i % 7 == 6) ins[15:10] = 6'h09 ^ 6'(1 << (i % 6));
      hit = ins[15:10] == 6'h09;
      axw(8'h00, {31'h0, ext}, r);
      axw(8'h04, {24'h0, acc}, r);
      axw(8'h08, {28'h0, bank}, r);
      axw(8'h0C, {24'h0, st}, r);
      axw(8'h10, {20'h0, idx}, r);
      chk("bresp", r, awf_pkg::RESP_OKAY);
      ea = eaddr(ins[8], ins[7:0]);
      m = u_mem.mem[ea];
      s = acc + m;
      exec(ins, hit, ea, s);
      axr(8'h04, d, r);
      chk("acc", d, {24'h0, (hit && !ins[9]) ? s : acc});
      axr(8'h0C, d, r);
      chk("status", d, {24'h0, hit ? flags(acc, m, st) : st});
      chk("rresp", r, awf_pkg::RESP_OKAY);
      if (hit) chk("file", u_mem.mem[ea], ins[9] ? s : m);
      if (hit) last_ea = ea;
      axr(8'h14, d, r);
      chk("info", d, {14'h0000, !hit, 1'b0, 4'h0, last_ea});
    end
    stop_test();
  end
endmodule
bind awf_execute awf_sva u_sva (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_instr(i_instr),
  .i_instr_valid(i_instr_valid), .o_instr_ready(o_instr_ready), .o_done(o_done), .o_mem_addr(o_mem_addr),
  .o_mem_rd(o_mem_rd), .o_mem_we(o_mem_we));
